// File: src/dpr_consts.svh
// Constants for the synchronous dual-port RAM port logic
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// Array geometry
`define DPR_ADDR_W     17
`define DPR_DATA_W     9
`define DPR_PORTS      2

// Address counter values
`define DPR_ADDR_ZERO  17'h0_0000
`define DPR_ADDR_STEP  17'h0_0001

// Reset values
`define DPR_DATA_RST   9'h000

`endif

// File: src/dpr_pkg.sv
// Types shared by the dual-port RAM port logic
`include "dpr_consts.svh"

package dpr_pkg;

    // Synchronous controls and data of one port, sampled on the rising edge
    typedef struct packed {
        logic                   chip_select_low_active;
        logic                   chip_select_high_active;
        logic                   rw_select;
        logic                   address_strobe_n;
        logic                   counter_advance_n;
        logic                   counter_clear_n;
        logic [`DPR_ADDR_W-1:0] addr;
        logic [`DPR_DATA_W-1:0] wdata;
    } dpr_port_in_t;

    // Kind of access taken at an edge
    typedef enum logic [1:0] {
        DPR_IDLE,
        DPR_READ,
        DPR_WRITE
    } dpr_access_t;

endpackage

// File: src/dpr_mem.sv
// Two-port storage array with registered read data on each port
`timescale 1ns/1ps

module dpr_mem #(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 9
) (
    // Clock
    input  wire logic              clk,
    // Port A
    input  wire logic              a_we,
    input  wire logic              a_re,
    input  wire logic [ADDR_W-1:0] a_addr,
    input  wire logic [DATA_W-1:0] a_wdata,
    output logic      [DATA_W-1:0] a_rdata,
    // Port B
    input  wire logic              b_we,
    input  wire logic              b_re,
    input  wire logic [ADDR_W-1:0] b_addr,
    input  wire logic [DATA_W-1:0] b_wdata,
    output logic      [DATA_W-1:0] b_rdata
);

    // The array needs at least one address bit and one data bit
    if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_geom
        $error("dpr_mem: ADDR_W and DATA_W must be at least 1");
    end

    logic [DATA_W-1:0] ram [0:(1<<ADDR_W)-1];

    // Writes from both ports; same-address writes in one cycle leave port B's word
    always_ff @(posedge clk) begin
        if (a_we) begin
            ram[a_addr] <= a_wdata;
        end
        if (b_we) begin
            ram[b_addr] <= b_wdata;
        end
    end

    // Reads return the word held before this edge; output holds when not read
    always_ff @(posedge clk) begin
        if (a_re) begin
            a_rdata <= ram[a_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (b_re) begin
            b_rdata <= ram[b_addr];
        end
    end

endmodule

// File: src/dpr_port_top.sv
// Two identical synchronous RAM ports sharing one storage array
`timescale 1ns/1ps
`include "dpr_consts.svh"

module dpr_port_top #(
    parameter int ADDR_W = `DPR_ADDR_W,
    parameter int DATA_W = `DPR_DATA_W
) (
    // Clock and reset
    input  wire logic                                        CORE_CLK,
    input  wire logic                                        RESETN,
    // Synchronous controls and write data, one entry per port
    input  wire dpr_pkg::dpr_port_in_t [`DPR_PORTS-1:0]      PORT_CTRL,
    // Asynchronous controls
    input  wire logic [`DPR_PORTS-1:0]                       OUTPUT_ENABLE_N,
    input  wire logic [`DPR_PORTS-1:0]                       OUTPUT_LATENCY_SELECT,
    // Data output and its enable
    output logic      [`DPR_PORTS-1:0][DATA_W-1:0]           DQ_O,
    output logic      [`DPR_PORTS-1:0]                       DQ_OE
);

    // Struct fields are fixed by the constants header
    if (ADDR_W != `DPR_ADDR_W || DATA_W != `DPR_DATA_W) begin : g_bad_width
        $error("dpr_port_top: ADDR_W and DATA_W must match the port struct widths");
    end

    // Address used at an edge: clear beats load beats advance beats hold
    function automatic logic [ADDR_W-1:0] next_addr(
        input dpr_pkg::dpr_port_in_t c,
        input logic [ADDR_W-1:0]     prev
    );
        logic [ADDR_W-1:0] res;
        res = prev;
        if (!c.counter_clear_n) begin
            res = `DPR_ADDR_ZERO;
        end else if (!c.address_strobe_n) begin
            res = c.addr;
        end else if (!c.counter_advance_n) begin
            res = ADDR_W'(prev + `DPR_ADDR_STEP);
        end
        return res;
    endfunction

    // Access kind decoded from the chip selects and read/write select
    function automatic dpr_pkg::dpr_access_t access_kind(input dpr_pkg::dpr_port_in_t c);
        dpr_pkg::dpr_access_t res;
        res = dpr_pkg::DPR_IDLE;
        if (!c.chip_select_low_active && c.chip_select_high_active) begin
            res = c.rw_select ? dpr_pkg::DPR_READ : dpr_pkg::DPR_WRITE;
        end
        return res;
    endfunction

    // Per-port state
    logic                 [ADDR_W-1:0] addr_r       [`DPR_PORTS];
    logic                 [ADDR_W-1:0] addr_nxt     [`DPR_PORTS];
    dpr_pkg::dpr_access_t              acc_nxt      [`DPR_PORTS];
    dpr_pkg::dpr_access_t              acc_r        [`DPR_PORTS];
    dpr_pkg::dpr_access_t              pipe_acc_r   [`DPR_PORTS];
    logic                 [DATA_W-1:0] pipe_data_r  [`DPR_PORTS];
    logic                 [DATA_W-1:0] flow_data    [`DPR_PORTS];
    logic                 [`DPR_PORTS-1:0] mem_we;
    logic                 [`DPR_PORTS-1:0] mem_re;
    logic                 [`DPR_PORTS-1:0] drive;

    for (genvar p = 0; p < `DPR_PORTS; p++) begin : g_port

        // Address and access decode from the pins present at the edge
        always_comb begin
            addr_nxt[p] = next_addr(PORT_CTRL[p], addr_r[p]);
            acc_nxt[p]  = access_kind(PORT_CTRL[p]);
        end

        // Array strobes act at the sampling edge itself
        assign mem_we[p] = (acc_nxt[p] == dpr_pkg::DPR_WRITE);
        assign mem_re[p] = (acc_nxt[p] == dpr_pkg::DPR_READ);

        // Address counter; runs whatever the chip selects
        always_ff @(posedge CORE_CLK or negedge RESETN) begin
            if (!RESETN) begin
                addr_r[p] <= `DPR_ADDR_ZERO;
            end else begin
                addr_r[p] <= addr_nxt[p];
            end
        end

        // Controls registered at the edge steer the output in the next cycle
        always_ff @(posedge CORE_CLK or negedge RESETN) begin
            if (!RESETN) begin
                acc_r[p]      <= dpr_pkg::DPR_IDLE;
                pipe_acc_r[p] <= dpr_pkg::DPR_IDLE;
            end else begin
                acc_r[p]      <= acc_nxt[p];
                pipe_acc_r[p] <= acc_r[p];
            end
        end

        // Second output stage used in pipelined mode
        always_ff @(posedge CORE_CLK or negedge RESETN) begin
            if (!RESETN) begin
                pipe_data_r[p] <= `DPR_DATA_RST;
            end else if (acc_r[p] == dpr_pkg::DPR_READ) begin
                pipe_data_r[p] <= flow_data[p];
            end
        end

        // Output select: latency select and output enable act without the clock
        always_comb begin
            if (OUTPUT_LATENCY_SELECT[p]) begin
                // Deselect at the last edge blanks a pending pipelined word
                drive[p]   = (pipe_acc_r[p] == dpr_pkg::DPR_READ)
                           && (acc_r[p] != dpr_pkg::DPR_IDLE);
                DQ_O[p]    = pipe_data_r[p];
            end else begin
                drive[p]   = (acc_r[p] == dpr_pkg::DPR_READ);
                DQ_O[p]    = flow_data[p];
            end
            DQ_OE[p] = drive[p] && !OUTPUT_ENABLE_N[p];
        end
    end

    // Shared array; a word written by one port is seen by the other from the next edge
    dpr_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_mem (
        .clk     (CORE_CLK),
        .a_we    (mem_we[0]),
        .a_re    (mem_re[0]),
        .a_addr  (addr_nxt[0]),
        .a_wdata (PORT_CTRL[0].wdata),
        .a_rdata (flow_data[0]),
        .b_we    (mem_we[1]),
        .b_re    (mem_re[1]),
        .b_addr  (addr_nxt[1]),
        .b_wdata (PORT_CTRL[1].wdata),
        .b_rdata (flow_data[1])
    );

endmodule

// File: verification/dpr_port_asserts.sv
// Concurrent checks on the outputs of the dual-port RAM ports
`timescale 1ns/1ps

module dpr_port_asserts #(
    parameter int DATA_W = 9
) (
    input wire logic                          CORE_CLK,
    input wire logic                          RESETN,
    input wire dpr_pkg::dpr_port_in_t [1:0]   PORT_CTRL,
    input wire logic [1:0]                    OUTPUT_ENABLE_N,
    input wire logic [1:0]                    OUTPUT_LATENCY_SELECT,
    input wire logic [1:0][DATA_W-1:0]        DQ_O,
    input wire logic [1:0]                    DQ_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    dpr_pkg::dpr_port_in_t c0;
    logic [1:0]            sel;
    logic                  rd0;
    logic                  lat0;
    logic                  hold0;

    assign c0    = PORT_CTRL[0];
    assign sel   = {!PORT_CTRL[1].chip_select_low_active && PORT_CTRL[1].chip_select_high_active,
                    !c0.chip_select_low_active && c0.chip_select_high_active};
    assign rd0   = sel[0] && c0.rw_select;
    assign lat0  = OUTPUT_LATENCY_SELECT[0];
    assign hold0 = c0.address_strobe_n && c0.counter_advance_n && c0.counter_clear_n;

    AST_DESEL_HIZ0: assert property (!sel[0] |=> !DQ_OE[0]) else $error("port 0 drives after deselect");
    AST_DESEL_HIZ1: assert property (!sel[1] |=> !DQ_OE[1]) else $error("port 1 drives after deselect");
    AST_OE_GATE: assert property ((DQ_OE & OUTPUT_ENABLE_N) == 2'h0) else $error("drive with enable off");
    AST_WR_NODRIVE: assert property (sel[0] && !c0.rw_select && !lat0 |=> lat0 || !DQ_OE[0])
        else $error("write cycle drives data");
    AST_FLOW_DRIVE: assert property (rd0 && !lat0 |=> lat0 || DQ_OE[0] == !OUTPUT_ENABLE_N[0])
        else $error("flow read not driven next cycle");
    AST_PIPE_DRIVE: assert property (rd0 && lat0 ##1 sel[0] |=> !lat0 || DQ_OE[0] == !OUTPUT_ENABLE_N[0])
        else $error("pipelined read not driven");
    AST_PIPE_LATE: assert property (!rd0 ##1 rd0 && lat0 |=> !lat0 || !DQ_OE[0])
        else $error("pipelined read drives one cycle early");
    AST_WR_RD: assert property (sel[0] && !c0.rw_select && !c0.address_strobe_n && c0.counter_clear_n
        ##1 rd0 && !lat0 && !c0.address_strobe_n && c0.counter_clear_n && c0.addr == $past(c0.addr)
        |=> DQ_O[0] == $past(c0.wdata, 2)) else $error("read after write returns wrong word");
    AST_HOLD: assert property (rd0 && !lat0 ##1 rd0 && !lat0 && hold0 |=> $stable(DQ_O[0]))
        else $error("held address changed the read word");

    COV_FLOW: cover property (rd0 && !lat0 ##1 DQ_OE[0]);
    COV_PIPE: cover property (rd0 && lat0 ##1 rd0 ##1 DQ_OE[0]);
    // Opposite-port read issued once the write-to-read delay has passed
    COV_CROSS: cover property (sel[1] && !PORT_CTRL[1].rw_select ##5 rd0);
endmodule

bind dpr_port_top dpr_port_asserts #(.DATA_W(DATA_W)) u_asserts (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .PORT_CTRL(PORT_CTRL), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .OUTPUT_LATENCY_SELECT(OUTPUT_LATENCY_SELECT),
    .DQ_O(DQ_O), .DQ_OE(DQ_OE));

// File: verification/dpr_ctrl_model.sv
// Memory controller model driving the synchronous inputs of one port
`timescale 1ns/1ps

module dpr_ctrl_model (
    input  wire logic            clk,
    output dpr_pkg::dpr_port_in_t ctrl
);
    // Deselected, counter untouched
    initial ctrl = {6'h2F, 17'h0, 9'h0};

    // A request changes just after an edge and holds for the whole next cycle
    task automatic issue(input dpr_pkg::dpr_port_in_t c);
        @(posedge clk);
        #1 ctrl = c;
    endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the dual-port RAM port pair
`timescale 1ns/1ps

module tb;
    // Control codes {select, read, strobe_n, advance_n, clear_n}
    localparam logic [4:0] WR = 5'h13, RD = 5'h1B, INC = 5'h1D, HLD = 5'h1F;
    localparam logic [4:0] IDL = 5'h0F, CLR = 5'h0E, RDC = 5'h1A, WHD = 5'h17;

    logic                         clk;
    logic                         rstn;
    logic [1:0]                   oen;
    logic [1:0]                   lat;
    wire dpr_pkg::dpr_port_in_t [1:0] pc;
    logic [1:0][8:0]              dq;
    logic [1:0]                   dq_oe;
    int                           n_errors = 0;
    int                           n_tests = 0;

    dpr_port_top u_dut (.CORE_CLK(clk), .RESETN(rstn), .PORT_CTRL(pc), .OUTPUT_ENABLE_N(oen),
        .OUTPUT_LATENCY_SELECT(lat), .DQ_O(dq), .DQ_OE(dq_oe));
    dpr_ctrl_model u_c0 (.clk(clk), .ctrl(pc[0]));
    dpr_ctrl_model u_c1 (.clk(clk), .ctrl(pc[1]));

    function automatic dpr_pkg::dpr_port_in_t op(input logic [4:0] c, input logic [16:0] a, input logic [8:0] d);
        op = '{!c[4], c[4], c[3], c[2], c[1], c[0], a, d};
    endfunction

    task automatic chk(input int p, input logic oe, input logic [8:0] d);
        n_tests++;
        if (dq_oe[p] !== oe || (oe && dq[p] !== d)) begin
            n_errors++;
            $display("ERROR %0t port %0d oe %b data %h", $time, p, dq_oe[p], dq[p]);
        end
    endtask

    task automatic t_flow();
        u_c0.issue(op(WR, 17'h101, 9'h05A));
        u_c0.issue(op(WR, 17'h100, 9'h1A5));
        u_c0.issue(op(RD, 17'h100, 9'h0));
        u_c0.issue(op(INC, 17'h1FFFF, 9'h0));
        chk(0, 1'b1, 9'h1A5);
        u_c0.issue(op(HLD, 17'h1FFFF, 9'h0));
        chk(0, 1'b1, 9'h05A);
        oen[0] = 1'b1;
        #1 chk(0, 1'b0, 9'h0);
        @(posedge clk);
        #1 oen[0] = 1'b0;
        u_c0.issue(op(IDL, 17'h0, 9'h0));
        chk(0, 1'b1, 9'h05A);
        u_c0.issue(op(WHD, 17'h0, 9'h0));
        chk(0, 1'b0, 9'h0);
        u_c0.issue(op(IDL, 17'h0, 9'h0));
        chk(0, 1'b0, 9'h0);
    endtask

    task automatic t_pipe();
        lat[0] = 1'b1;
        u_c0.issue(op(CLR, 17'h333, 9'h0));
        u_c0.issue(op(WHD, 17'h333, 9'h0C3));
        u_c0.issue(op(RDC, 17'h333, 9'h0));
        u_c0.issue(op(HLD, 17'h333, 9'h0));
        chk(0, 1'b0, 9'h0);
        u_c0.issue(op(IDL, 17'h0, 9'h0));
        chk(0, 1'b1, 9'h0C3);
        u_c0.issue(op(WR, 17'h0, 9'h0C3));
        chk(0, 1'b0, 9'h0);
    endtask

    task automatic t_cross();
        lat = 2'b10;
        u_c1.issue(op(WR, 17'h10040, 9'h111));
        fork
            u_c1.issue(op(IDL, 17'h0, 9'h0));
            u_c0.issue(op(IDL, 17'h0, 9'h0));
        join
        // Reader waits out the write-to-read delay before taking the word
        repeat (3) @(posedge clk);
        u_c0.issue(op(RD, 17'h10040, 9'h0));
        fork
            u_c1.issue(op(RD, 17'h10040, 9'h0));
            u_c0.issue(op(IDL, 17'h0, 9'h0));
        join
        chk(0, 1'b1, 9'h111);
        u_c1.issue(op(HLD, 17'h0, 9'h0));
        chk(1, 1'b0, 9'h0);
        u_c1.issue(op(IDL, 17'h0, 9'h0));
        chk(1, 1'b1, 9'h111);
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        oen = 2'b00;
        lat = 2'b00;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        t_flow();
        t_pipe();
        t_cross();
        print_verdict();
    end

    // About 27 cycles are needed; cut a hang well beyond that
    initial begin
        #2000;
        n_errors++;
        print_verdict();
    end
endmodule
